// [core/pim_defines.svh]
`ifndef PIM_DEFINES_SVH
`define PIM_DEFINES_SVH

// Register subaddresses
`define PIM_ADDR_CORE_EVT     8'h01
`define PIM_ADDR_SW_EVT       8'h02
`define PIM_ADDR_CORE_MASK    8'h03
`define PIM_ADDR_SW_MASK      8'h04
`define PIM_ADDR_STATUS       8'h05
`define PIM_ADDR_CONTROL      8'h06

// Switch event flag positions
`define PIM_SW3_FAULT_BIT     5
`define PIM_SW2_FAULT_BIT     4
`define PIM_SW1_FAULT_BIT     3
`define PIM_SW3_LIMIT_BIT     2
`define PIM_SW2_LIMIT_BIT     1
`define PIM_SW1_LIMIT_BIT     0

// Core event positions
`define PIM_PROG_LOW_BIT      5
`define PIM_LINE_BIT          4
`define PIM_BUTTON_BIT        3
`define PIM_OVERTEMP_BIT      2
`define PIM_ACQ_DONE_BIT      1
`define PIM_PROG_DONE_BIT     0

// Status positions
`define PIM_SEAL_BIT          7
`define PIM_DEFAULTS_BIT      6
`define PIM_LINE_LVL_BIT      5
`define PIM_BUTTON_LVL_BIT    4
`define PIM_SEQ_HI            3
`define PIM_SEQ_LO            2
`define PIM_CELL_HI           1
`define PIM_CELL_LO           0

`define PIM_CELL_ACQ_BIT      0
`define PIM_MASK_USED         8'h3F
`define PIM_MASK_RESET        8'h00
`define PIM_EVT_RESET         8'h00

`endif

// [core/pim_irq_mask_status.sv]
`timescale 1ns/1ps
`include "pim_defines.svh"

module pim_irq_mask_status
(
  input  wire logic              mclk_i,
  input  wire logic              resetn_i,
  // Register port from the serial front end
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  input  wire logic [7:0]        reg_addr_i,
  input  wire pim_pkg::pim_byte_t reg_wdata_i,
  output logic [7:0]             reg_rdata_o,
  // Load switch monitors
  input  wire logic [3:1]        sw_overtemp_i,
  input  wire logic              sw2_undervolt_i,
  input  wire logic [3:1]        sw_limiting_i,
  // Core event pulses
  input  wire logic              prog_voltage_low_i,
  input  wire logic              overtemp_warn_i,
  input  wire logic              cell_acq_done_i,
  input  wire logic              prog_done_i,
  // Live status sources
  input  wire logic              line_detect_in_n_i,
  input  wire logic              button_in_n_i,
  input  wire logic              freshness_seal_broken_i,
  input  wire logic              defaults_modified_i,
  input  wire pim_pkg::pim_seq_e seq_state_i,
  input  wire logic [1:0]        cell_charge_class_i,
  // Outputs
  output logic                   cell_acq_start_o,
  output logic                   irq_out_n_o,
  output logic                   irq_out_n_oe_n_o
);
  import pim_pkg::*;

  logic [7:0] core_evt_ff;
  logic [7:0] nxt_core_evt;
  logic [7:0] sw_evt_ff;
  logic [7:0] nxt_sw_evt;
  logic [7:0] core_mask_ff;
  logic [7:0] nxt_core_mask;
  logic [7:0] sw_mask_ff;
  logic [7:0] nxt_sw_mask;
  logic [7:0] status_ff;
  logic [7:0] nxt_status;
  logic       line_prev_ff;
  logic       nxt_line_prev;
  logic       button_prev_ff;
  logic       nxt_button_prev;
  logic       acq_ff;
  logic       nxt_acq;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  logic       irq_n_ff;
  logic       nxt_irq_n;
  logic       oe_n_ff;
  logic       nxt_oe_n;
  logic [7:0] core_set;
  logic [7:0] sw_set;
  logic       pending;
  logic       hit_core_evt;
  logic       hit_sw_evt;
  // Named views of the flag bits
  logic       prog_voltage_low_flag;
  logic       line_detect_flag;
  logic       button_flag;
  logic       overtemp_warn_flag;
  logic       cell_acq_done_flag;
  logic       prog_done_flag;
  logic       switch3_thermal_fault;
  logic       switch2_fault;
  logic       switch1_thermal_fault;
  logic       switch3_current_limiting;
  logic       switch2_current_limiting;
  logic       switch1_current_limiting;
  // Named views of the mask bits
  logic       prog_voltage_low_mask;
  logic       line_detect_mask;
  logic       button_mask;
  logic       overtemp_warn_mask;
  logic       cell_acq_done_mask;
  logic       prog_done_mask;
  logic       switch3_fault_mask;
  logic       switch2_fault_mask;
  logic       switch1_fault_mask;
  logic       switch3_limit_mask;
  logic       switch2_limit_mask;
  logic       switch1_limit_mask;
  // One request per event after its mask
  logic [5:0] core_req;
  logic [5:0] sw_req;

  // Subaddress decode for the read-clear path
  always_comb
  begin
    // Only reads of the two flag registers clear anything
    hit_core_evt = (reg_addr_i == `PIM_ADDR_CORE_EVT);
    hit_sw_evt   = (reg_addr_i == `PIM_ADDR_SW_EVT);
  end

  // Event sources and flag update
  always_comb
  begin
    core_set = 8'h00;
    core_set[`PIM_PROG_LOW_BIT]  = prog_voltage_low_i;
    core_set[`PIM_LINE_BIT]      = line_detect_in_n_i ^ line_prev_ff;
    core_set[`PIM_BUTTON_BIT]    = button_in_n_i ^ button_prev_ff;
    core_set[`PIM_OVERTEMP_BIT]  = overtemp_warn_i;
    core_set[`PIM_ACQ_DONE_BIT]  = cell_acq_done_i;
    core_set[`PIM_PROG_DONE_BIT] = prog_done_i;

    sw_set = 8'h00;
    sw_set[`PIM_SW3_FAULT_BIT] = sw_overtemp_i[3];
    sw_set[`PIM_SW2_FAULT_BIT] = sw_overtemp_i[2] | sw2_undervolt_i;
    sw_set[`PIM_SW1_FAULT_BIT] = sw_overtemp_i[1];

    nxt_core_evt = core_evt_ff;
    nxt_sw_evt   = sw_evt_ff;
    // Read clears, but a same-cycle event survives the clear
    if (reg_rd_i && hit_core_evt)
    begin
      nxt_core_evt = `PIM_EVT_RESET;
    end
    if (reg_rd_i && hit_sw_evt)
    begin
      nxt_sw_evt = `PIM_EVT_RESET;
    end
    // Flags update whatever the masks hold
    nxt_core_evt = (nxt_core_evt | core_set) & `PIM_MASK_USED;
    nxt_sw_evt   = (nxt_sw_evt | sw_set) & `PIM_MASK_USED;
    // Limit bits are live levels, not sticky
    nxt_sw_evt[`PIM_SW3_LIMIT_BIT] = sw_limiting_i[3];
    nxt_sw_evt[`PIM_SW2_LIMIT_BIT] = sw_limiting_i[2];
    nxt_sw_evt[`PIM_SW1_LIMIT_BIT] = sw_limiting_i[1];

    nxt_line_prev   = line_detect_in_n_i;
    nxt_button_prev = button_in_n_i;
  end

  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      core_evt_ff    <= `PIM_EVT_RESET;
      sw_evt_ff      <= `PIM_EVT_RESET;
      line_prev_ff   <= 1'b1;
      button_prev_ff <= 1'b1;
    end
    else
    begin
      core_evt_ff    <= nxt_core_evt;
      sw_evt_ff      <= nxt_sw_evt;
      line_prev_ff   <= nxt_line_prev;
      button_prev_ff <= nxt_button_prev;
    end
  end

  // Mask and control registers
  always_comb
  begin
    nxt_core_mask = core_mask_ff;
    nxt_sw_mask   = sw_mask_ff;
    nxt_acq       = 1'b0;
    if (reg_wr_i)
    begin
      case (reg_addr_i)
        `PIM_ADDR_CORE_MASK:
          nxt_core_mask = reg_wdata_i & `PIM_MASK_USED;
        `PIM_ADDR_SW_MASK:
          nxt_sw_mask = reg_wdata_i & `PIM_MASK_USED;
        `PIM_ADDR_CONTROL:
          nxt_acq = reg_wdata_i[`PIM_CELL_ACQ_BIT];
        default:
          nxt_acq = 1'b0;
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      core_mask_ff <= `PIM_MASK_RESET;
      sw_mask_ff   <= `PIM_MASK_RESET;
      acq_ff       <= 1'b0;
    end
    else
    begin
      core_mask_ff <= nxt_core_mask;
      sw_mask_ff   <= nxt_sw_mask;
      acq_ff       <= nxt_acq;
    end
  end

  // Live status word, one register stage from the pins
  always_comb
  begin
    nxt_status = 8'h00;
    nxt_status[`PIM_SEAL_BIT]       = freshness_seal_broken_i;
    nxt_status[`PIM_DEFAULTS_BIT]   = defaults_modified_i;
    nxt_status[`PIM_LINE_LVL_BIT]   = ~line_detect_in_n_i;
    nxt_status[`PIM_BUTTON_LVL_BIT] = ~button_in_n_i;
    nxt_status[`PIM_SEQ_HI:`PIM_SEQ_LO] = seq_state_i;
    // Only meaningful after an acquisition has completed
    nxt_status[`PIM_CELL_HI:`PIM_CELL_LO] = cell_charge_class_i;
  end

  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      status_ff <= 8'h00;
    end
    else
    begin
      status_ff <= nxt_status;
    end
  end

  // Named views keep the gating below readable against the bit map
  assign prog_voltage_low_flag    = core_evt_ff[`PIM_PROG_LOW_BIT];
  assign line_detect_flag         = core_evt_ff[`PIM_LINE_BIT];
  assign button_flag              = core_evt_ff[`PIM_BUTTON_BIT];
  assign overtemp_warn_flag       = core_evt_ff[`PIM_OVERTEMP_BIT];
  assign cell_acq_done_flag       = core_evt_ff[`PIM_ACQ_DONE_BIT];
  assign prog_done_flag           = core_evt_ff[`PIM_PROG_DONE_BIT];
  assign switch3_thermal_fault    = sw_evt_ff[`PIM_SW3_FAULT_BIT];
  assign switch2_fault            = sw_evt_ff[`PIM_SW2_FAULT_BIT];
  assign switch1_thermal_fault    = sw_evt_ff[`PIM_SW1_FAULT_BIT];
  assign switch3_current_limiting = sw_evt_ff[`PIM_SW3_LIMIT_BIT];
  assign switch2_current_limiting = sw_evt_ff[`PIM_SW2_LIMIT_BIT];
  assign switch1_current_limiting = sw_evt_ff[`PIM_SW1_LIMIT_BIT];

  // Mask fields sit at the same positions as their flags
  assign prog_voltage_low_mask    = core_mask_ff[`PIM_PROG_LOW_BIT];
  assign line_detect_mask         = core_mask_ff[`PIM_LINE_BIT];
  assign button_mask              = core_mask_ff[`PIM_BUTTON_BIT];
  assign overtemp_warn_mask       = core_mask_ff[`PIM_OVERTEMP_BIT];
  assign cell_acq_done_mask       = core_mask_ff[`PIM_ACQ_DONE_BIT];
  assign prog_done_mask           = core_mask_ff[`PIM_PROG_DONE_BIT];
  assign switch3_fault_mask       = sw_mask_ff[`PIM_SW3_FAULT_BIT];
  assign switch2_fault_mask       = sw_mask_ff[`PIM_SW2_FAULT_BIT];
  assign switch1_fault_mask       = sw_mask_ff[`PIM_SW1_FAULT_BIT];
  assign switch3_limit_mask       = sw_mask_ff[`PIM_SW3_LIMIT_BIT];
  assign switch2_limit_mask       = sw_mask_ff[`PIM_SW2_LIMIT_BIT];
  assign switch1_limit_mask       = sw_mask_ff[`PIM_SW1_LIMIT_BIT];

  // Masking gates only the pin; the flags above never see it
  always_comb
  begin
    core_req = 6'h00;
    core_req[`PIM_PROG_LOW_BIT]  = prog_voltage_low_flag
                                 & ~prog_voltage_low_mask;
    core_req[`PIM_LINE_BIT]      = line_detect_flag
                                 & ~line_detect_mask;
    core_req[`PIM_BUTTON_BIT]    = button_flag
                                 & ~button_mask;
    core_req[`PIM_OVERTEMP_BIT]  = overtemp_warn_flag
                                 & ~overtemp_warn_mask;
    core_req[`PIM_ACQ_DONE_BIT]  = cell_acq_done_flag
                                 & ~cell_acq_done_mask;
    core_req[`PIM_PROG_DONE_BIT] = prog_done_flag
                                 & ~prog_done_mask;

    // Fault requests stay until read; limit requests follow the level
    sw_req = 6'h00;
    sw_req[`PIM_SW3_FAULT_BIT] = switch3_thermal_fault
                               & ~switch3_fault_mask;
    sw_req[`PIM_SW2_FAULT_BIT] = switch2_fault
                               & ~switch2_fault_mask;
    sw_req[`PIM_SW1_FAULT_BIT] = switch1_thermal_fault
                               & ~switch1_fault_mask;
    sw_req[`PIM_SW3_LIMIT_BIT] = switch3_current_limiting
                               & ~switch3_limit_mask;
    sw_req[`PIM_SW2_LIMIT_BIT] = switch2_current_limiting
                               & ~switch2_limit_mask;
    sw_req[`PIM_SW1_LIMIT_BIT] = switch1_current_limiting
                               & ~switch1_limit_mask;
  end

  // Read mux and interrupt pin
  always_comb
  begin
    case (reg_addr_i)
      `PIM_ADDR_CORE_EVT:  nxt_rdata = core_evt_ff;
      `PIM_ADDR_SW_EVT:    nxt_rdata = sw_evt_ff;
      `PIM_ADDR_CORE_MASK: nxt_rdata = core_mask_ff;
      `PIM_ADDR_SW_MASK:   nxt_rdata = sw_mask_ff;
      `PIM_ADDR_STATUS:    nxt_rdata = status_ff;
      `PIM_ADDR_CONTROL:   nxt_rdata = 8'h00; // Start bit reads back clear
      default:             nxt_rdata = 8'h00;
    endcase
    if (!reg_rd_i)
    begin
      nxt_rdata = rdata_ff;
    end
    // Any unmasked flag holds the pin low until it is read away; limit flags hold it only while their level lasts
    pending = (|core_req) | (|sw_req);
    // Open drain: drive low when pending, release otherwise
    nxt_irq_n = 1'b0;
    nxt_oe_n  = ~pending;
  end

  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      rdata_ff <= 8'h00;
      irq_n_ff <= 1'b0;
      oe_n_ff  <= 1'b1;
    end
    else
    begin
      rdata_ff <= nxt_rdata;
      irq_n_ff <= nxt_irq_n;
      oe_n_ff  <= nxt_oe_n;
    end
  end

  assign reg_rdata_o      = rdata_ff;
  assign cell_acq_start_o = acq_ff;
  assign irq_out_n_o      = irq_n_ff;
  assign irq_out_n_oe_n_o = oe_n_ff;

endmodule

// [core/pim_pkg.sv]
package pim_pkg;
  typedef enum logic [1:0] {
    PIM_SEQ_TRANSITION,
    PIM_SEQ_AWAIT_POWER_ENABLE,
    PIM_SEQ_ACTIVE,
    PIM_SEQ_SUSPEND
  } pim_seq_e;

  typedef logic [7:0] pim_byte_t;
endpackage

// [tb/pim_host_model.sv]
`timescale 1ns/1ps
module pim_host_model
(
  input  wire logic irq_out_n_i,
  input  wire logic irq_out_n_oe_n_i,
  output logic      irq_line_o
);
  // Board pull-up: the line only goes low while the device sinks it
  assign irq_line_o = irq_out_n_oe_n_i ? 1'b1 : irq_out_n_i;
endmodule

// [tb/pim_irq_mask_status_properties.sv]
`timescale 1ns/1ps
module pim_irq_mask_status_properties
(
  input wire logic             mclk_i,
  input wire logic             resetn_i,
  input wire logic             reg_wr_i,
  input wire logic             reg_rd_i,
  input wire logic [7:0]       reg_addr_i,
  input wire pim_pkg::pim_byte_t reg_wdata_i,
  input wire logic [7:0]       reg_rdata_o,
  input wire logic [3:1]       sw_overtemp_i,
  input wire logic [3:1]       sw_limiting_i,
  input wire logic             freshness_seal_broken_i,
  input wire logic             defaults_modified_i,
  input wire logic             line_detect_in_n_i,
  input wire logic             button_in_n_i,
  input wire pim_pkg::pim_seq_e seq_state_i,
  input wire logic [1:0]       cell_charge_class_i,
  input wire logic             cell_acq_start_o,
  input wire logic             irq_out_n_oe_n_o
);
  import pim_pkg::*;
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!resetn_i);
  logic [7:0] stat_w;
  logic [2:0] lim_mask_ff;
  assign stat_w = {freshness_seal_broken_i, defaults_modified_i,
    !line_detect_in_n_i, !button_in_n_i, seq_state_i, cell_charge_class_i};
  // Shadow of the limit masks, so the pin can be judged without the body
  always_ff @(posedge mclk_i or negedge resetn_i)
    if (!resetn_i)
      lim_mask_ff <= 3'h0;
    else if (reg_wr_i && reg_addr_i == 8'h04)
      lim_mask_ff <= reg_wdata_i[2:0];
  sequence s_rd(logic [7:0] a);
    reg_rd_i && reg_addr_i == a;
  endsequence
  sequence s_wr(logic [7:0] a);
    reg_wr_i && reg_addr_i == a;
  endsequence
  sequence s_pulse;
    cell_acq_start_o ##1 !cell_acq_start_o;
  endsequence
  a_mask_readback: assert property (s_wr(8'h03) ##1 s_rd(8'h03) |=>
    reg_rdata_o == ($past(reg_wdata_i, 2) & 8'h3F))
    else $error("mask readback wrong");
  a_limit_read: assert property (s_rd(8'h02) |=>
    reg_rdata_o[2:0] == $past(sw_limiting_i, 2))
    else $error("limit bits wrong");
  a_fault_set: assert property (s_rd(8'h02) |=>
    (reg_rdata_o[5:3] & $past(sw_overtemp_i, 2)) == $past(sw_overtemp_i, 2))
    else $error("fault bits missing");
  a_status_read: assert property (s_rd(8'h05) |=>
    reg_rdata_o == $past(stat_w, 2))
    else $error("status byte wrong");
  a_unmapped_zero: assert property (reg_rd_i &&
    !(reg_addr_i inside {[8'h01:8'h05]}) |=> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  a_acq_pulse: assert property (reg_wr_i && reg_addr_i == 8'h06 &&
    reg_wdata_i[0] |=> s_pulse)
    else $error("start pulse wrong");
  a_limit_irq: assert property ((sw_limiting_i & ~lim_mask_ff) != 3'h0
    |-> ##2 !irq_out_n_oe_n_o)
    else $error("unmasked limit left pin released");
  a_rdata_hold: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
    else $error("read data moved without a read");
endmodule

bind pim_irq_mask_status pim_irq_mask_status_properties
  pim_irq_mask_status_properties_inst
  (
    .mclk_i                  (mclk_i),
    .resetn_i                (resetn_i),
    .reg_wr_i                (reg_wr_i),
    .reg_rd_i                (reg_rd_i),
    .reg_addr_i              (reg_addr_i),
    .reg_wdata_i             (reg_wdata_i),
    .reg_rdata_o             (reg_rdata_o),
    .sw_overtemp_i           (sw_overtemp_i),
    .sw_limiting_i           (sw_limiting_i),
    .freshness_seal_broken_i (freshness_seal_broken_i),
    .defaults_modified_i     (defaults_modified_i),
    .line_detect_in_n_i      (line_detect_in_n_i),
    .button_in_n_i           (button_in_n_i),
    .seq_state_i             (seq_state_i),
    .cell_charge_class_i     (cell_charge_class_i),
    .cell_acq_start_o        (cell_acq_start_o),
    .irq_out_n_oe_n_o        (irq_out_n_oe_n_o)
  );

// [tb/tb_pim_irq_mask_status.sv]
`timescale 1ns/1ps
module tb_pim_irq_mask_status;
  import pim_pkg::*;
  logic       mclk_i, resetn_i, reg_wr_i, reg_rd_i, sw2_undervolt_i;
  logic       line_detect_in_n_i, button_in_n_i, rd_pend;
  logic       freshness_seal_broken_i, defaults_modified_i;
  logic       cell_acq_start_o, irq_out_n_o, irq_out_n_oe_n_o, irq_line;
  logic [7:0] reg_addr_i, reg_rdata_o, r;
  pim_byte_t  reg_wdata_i;
  logic [3:1] sw_overtemp_i, sw_limiting_i;
  logic [1:0] cell_charge_class_i;
  logic [5:0] ev;
  pim_seq_e   seq_state_i;
  pim_byte_t  exp_q[$];
  int         miscompares, check_count;
  wire        prog_voltage_low_i = ev[5];
  wire        overtemp_warn_i = ev[2];
  wire        cell_acq_done_i = ev[1];
  wire        prog_done_i = ev[0];

  pim_irq_mask_status pim_irq_mask_status_inst
  (
    .mclk_i                  (mclk_i),
    .resetn_i                (resetn_i),
    .reg_wr_i                (reg_wr_i),
    .reg_rd_i                (reg_rd_i),
    .reg_addr_i              (reg_addr_i),
    .reg_wdata_i             (reg_wdata_i),
    .reg_rdata_o             (reg_rdata_o),
    .sw_overtemp_i           (sw_overtemp_i),
    .sw2_undervolt_i         (sw2_undervolt_i),
    .sw_limiting_i           (sw_limiting_i),
    .prog_voltage_low_i      (prog_voltage_low_i),
    .overtemp_warn_i         (overtemp_warn_i),
    .cell_acq_done_i         (cell_acq_done_i),
    .prog_done_i             (prog_done_i),
    .line_detect_in_n_i      (line_detect_in_n_i),
    .button_in_n_i           (button_in_n_i),
    .freshness_seal_broken_i (freshness_seal_broken_i),
    .defaults_modified_i     (defaults_modified_i),
    .seq_state_i             (seq_state_i),
    .cell_charge_class_i     (cell_charge_class_i),
    .cell_acq_start_o        (cell_acq_start_o),
    .irq_out_n_o             (irq_out_n_o),
    .irq_out_n_oe_n_o        (irq_out_n_oe_n_o)
  );
  pim_host_model pim_host_model_inst
  (
    .irq_out_n_i      (irq_out_n_o),
    .irq_out_n_oe_n_i (irq_out_n_oe_n_o),
    .irq_line_o       (irq_line)
  );

  initial
  begin
    mclk_i = 0;
    forever #20 mclk_i = ~mclk_i;
  end

  task automatic chk8(string n, pim_byte_t e, pim_byte_t g);
    check_count++;
    if (g !== e)
    begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk1(string n, logic e, logic g);
    check_count++;
    if (g !== e)
    begin
      miscompares++;
      $display("mismatch %s expected %b seen %b", n, e, g);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // For a read, d is the expected byte and goes to the scoreboard
  task automatic acc(logic w, logic [7:0] a, pim_byte_t d);
    reg_wr_i = w;
    reg_rd_i = !w;
    reg_addr_i = a;
    reg_wdata_i = d;
    if (!w)
      exp_q.push_back(d);
    @(posedge mclk_i);
    #2;
  endtask

  task automatic idle(int n);
    reg_wr_i = 0;
    reg_rd_i = 0;
    repeat (n) @(posedge mclk_i);
    #2;
  endtask

  task automatic wait_irq(logic lvl);
    int k;
    k = 0;
    while (irq_line !== lvl && k < 8)
    begin
      @(posedge mclk_i);
      #2;
      k++;
    end
    chk1("irq line", lvl, irq_line);
    if (irq_line !== lvl)
      conclude();
  endtask

  // Sampled mid-cycle, where the byte from the last read edge has settled
  always @(negedge mclk_i)
  begin
    if (rd_pend)
      chk8("read data", exp_q.pop_front(), reg_rdata_o);
    rd_pend = reg_rd_i;
  end

  initial
  begin
    {reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i, ev, rd_pend} = '0;
    {resetn_i, sw_overtemp_i, sw2_undervolt_i, sw_limiting_i} = '0;
    {freshness_seal_broken_i, defaults_modified_i, cell_charge_class_i} = '0;
    {line_detect_in_n_i, button_in_n_i} = 2'b11;
    seq_state_i = PIM_SEQ_TRANSITION;
    void'($urandom(17688));
    repeat (3) @(posedge mclk_i);
    #2;
    resetn_i = 1;
    idle(2);
    for (int a = 0; a < 8; a++)
      acc(0, a[7:0], 8'h00);
    idle(1);
    chk1("irq idle", 1'b1, irq_line);
    $display("reset test done");
    r = $urandom;
    acc(1, 8'h03, r | 8'hC0);
    acc(0, 8'h03, r & 8'h3F);
    acc(1, 8'h04, ~r);
    acc(0, 8'h04, ~r & 8'h3F);
    acc(1, 8'h02, 8'hFF);
    acc(1, 8'h05, 8'hFF);
    acc(0, 8'h02, 8'h00);
    acc(0, 8'h05, 8'h00);
    acc(1, 8'h03, 8'hFF);
    acc(1, 8'h04, 8'hFF);
    idle(1);
    $display("mask test done");
    sw_overtemp_i = 3'b101;
    sw2_undervolt_i = 1;
    sw_limiting_i = 3'b011;
    idle(3);
    chk1("irq masked", 1'b1, irq_line);
    acc(0, 8'h02, 8'h3B);
    {sw_overtemp_i, sw2_undervolt_i, sw_limiting_i} = '0;
    idle(2);
    acc(0, 8'h02, 8'h38);
    acc(0, 8'h02, 8'h00);
    acc(1, 8'h04, 8'h3B);
    idle(1);
    sw_limiting_i = 3'b100;
    wait_irq(1'b0);
    acc(0, 8'h02, 8'h04);
    sw_limiting_i = 3'b000;
    idle(3);
    chk1("irq released", 1'b1, irq_line);
    sw_overtemp_i = 3'b010;
    idle(2);
    acc(0, 8'h02, 8'h10);
    sw_overtemp_i = 3'b000;
    acc(0, 8'h02, 8'h10);
    $display("switch test done");
    acc(1, 8'h03, 8'h00);
    for (int i = 0; i < 6; i++)
    begin
      ev = 6'h01 << i;
      line_detect_in_n_i ^= ev[4];
      button_in_n_i ^= ev[3];
      idle(1);
      ev = '0;
      wait_irq(1'b0);
      acc(0, 8'h01, 8'h01 << i);
      idle(3);
      chk1("irq cleared", 1'b1, irq_line);
    end
    $display("core event test done");
    acc(1, 8'h06, 8'h01);
    chk1("acq start", 1'b1, cell_acq_start_o);
    idle(1);
    chk1("acq end", 1'b0, cell_acq_start_o);
    acc(0, 8'h06, 8'h00);
    $display("acquisition test done");
    for (int k = 0; k < 4; k++)
    begin
      {freshness_seal_broken_i, defaults_modified_i} = k[1:0];
      seq_state_i = pim_seq_e'(k);
      cell_charge_class_i = 2'($urandom);
      idle(2);
      acc(0, 8'h05, {k[1:0], 2'b11, k[1:0], cell_charge_class_i});
    end
    idle(2);
    $display("status test done");
    conclude();
  end
endmodule
